// File: bench/diag_bank_asserts.sv
`timescale 1ns/1ps
// ==========================================================================
// Read port and summary flag checks
module diag_bank_asserts
    import diag_bank_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Register port
    input wire logic [9:0] reg_addr,
    input wire logic reg_read,
    input wire logic [7:0] reg_rdata,
    // Monitor flags
    input wire logic battery_overvoltage,
    input wire logic tracker_overtemp,
    input wire logic main_regulator_overtemp,
    input wire logic main_relay_overtemp,
    input wire logic lin_transceiver_overtemp,
    input wire logic other_overtemp,
    // Summary outputs
    input wire logic central_failure_flag,
    input wire logic central_overtemp_flag
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    // Six samples cover two sync stages plus the status register
    wire logic any_hot = tracker_overtemp | main_regulator_overtemp | main_relay_overtemp
        | lin_transceiver_overtemp | other_overtemp;
    idle_rdata_zero_a: assert property (!reg_read |=> reg_rdata == 8'h00)
        else $error("read data not zero outside an answer");
    unmapped_zero_a: assert property (reg_read && (reg_addr < 10'h020 || reg_addr > 10'h024)
        |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
    temp_reserved_a: assert property (reg_read && reg_addr == overtemperature_diagnosis_off
        |=> reg_rdata[7:3] == 5'h00) else $error("overtemp reserved bits set");
    sensor_reserved_a: assert property (reg_read && reg_addr == reluctance_sensor_flags_off
        |=> reg_rdata[7:5] == 3'h0) else $error("sensor reserved bits set");
    comm_reserved_a: assert property (reg_read && reg_addr == communication_diagnosis_off
        |=> {reg_rdata[7:6], reg_rdata[4:0]} == 7'h00) else $error("comm reserved bits set");
    lin_bit_read_a: assert property ((rst_n && lin_transceiver_overtemp)[*6] ##0
        (reg_read && reg_addr == communication_diagnosis_off) |=> reg_rdata[5])
        else $error("lin overtemp bit not read as one");
    overtemp_set_a: assert property ((rst_n && tracker_overtemp)[*6] |=> central_overtemp_flag)
        else $error("central overtemp flag missing");
    overtemp_clear_a: assert property ((rst_n && !any_hot)[*6] |=> !central_overtemp_flag)
        else $error("central overtemp flag without cause");
    failure_set_a: assert property ((rst_n && battery_overvoltage)[*6] |=> central_failure_flag)
        else $error("central failure flag missing");
endmodule

bind diagnosis_status_bank diag_bank_asserts diag_bank_asserts_inst (.clock, .rst_n, .reg_addr,
    .reg_read, .reg_rdata, .battery_overvoltage, .tracker_overtemp, .main_regulator_overtemp,
    .main_relay_overtemp, .lin_transceiver_overtemp, .other_overtemp, .central_failure_flag,
    .central_overtemp_flag);

// File: bench/diagnosis_status_bank_test.sv
`timescale 1ns/1ps
// ==========================================================================
// Self-checking bench: all single-bit monitor inputs packed in one vector
module diagnosis_status_bank_test;
    import diag_bank_pkg::*;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic [9:0] reg_addr = 10'h000;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [17:0] s = 18'h0;
    logic [6:0] m = 7'h00;
    wire logic [7:0] reg_rdata;
    wire logic fail_flag;
    wire logic hot_flag;
    int n_errors = 0;
    int tests_run = 0;
    diagnosis_status_bank diagnosis_status_bank_inst (.clock(clock), .rst_n(rst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .six_volt_supply_overvoltage(s[5]), .tracker_two_overvoltage(s[4]),
        .tracker_two_undervoltage(s[3]), .tracker_one_overvoltage(s[2]),
        .tracker_one_undervoltage(s[1]), .battery_overvoltage(s[0]), .other_failure(s[11]),
        .tracker_overtemp(s[8]), .main_regulator_overtemp(s[7]), .main_relay_overtemp(s[6]),
        .lin_transceiver_overtemp(s[9]), .other_overtemp(s[10]), .open_load_data_valid(s[16]),
        .short_data_valid(s[15]), .sensor_open_load(s[14]), .sensor_short_battery(s[13]),
        .sensor_short_ground(s[12]), .converter_data_valid(s[17]), .sensor_measure_result(m),
        .central_failure_flag(fail_flag), .central_overtemp_flag(hot_flag));
    // Clock at 200 MHz
    initial begin
        forever #2.5 clock = ~clock;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [9:0] a, output logic [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        #1 d = reg_rdata;
    endtask
    // Waits out the sync latency, then reads every register and the flags
    task automatic check_all();
        logic [7:0] d;
        logic f;
        logic t;
        repeat (6) @(posedge clock);
        #1;
        t = |s[10:6];
        f = |s[5:0] | t | |s[14:12] | s[11];
        chk({7'h0, fail_flag}, {7'h0, f});
        chk({7'h0, hot_flag}, {7'h0, t});
        rd(supply_diagnosis_off, d);
        chk(d, {s[5:0], f, t});
        rd(overtemperature_diagnosis_off, d);
        chk(d, {5'h00, s[8:6]});
        rd(reluctance_sensor_flags_off, d);
        chk(d, {3'h0, s[16:12]});
        rd(reluctance_sensor_measure_off, d);
        chk(d, {s[17], m});
        rd(communication_diagnosis_off, d);
        chk(d, {2'h0, s[9], 5'h00});
        rd(10'h025, d);
        chk(d, 8'h00);
    endtask
    // One input at a time, then all, then back to quiet
    task automatic test_walk();
        for (int i = 0; i < 18; i++) begin
            @(posedge clock);
            s <= 18'h1 << i;
            m <= 7'h01 << (i % 7);
            check_all();
        end
        @(posedge clock);
        s <= 18'h3ffff;
        m <= 7'h7f;
        check_all();
        @(posedge clock);
        s <= 18'h0;
        m <= 7'h00;
        check_all();
        $display("walk test done");
    endtask
    // Writes to every register must leave the contents alone
    task automatic test_write();
        @(posedge clock);
        s <= 18'h2aaaa;
        m <= 7'h55;
        for (int a = 'h20; a < 'h26; a++) begin
            @(posedge clock);
            reg_addr <= a[9:0];
            reg_wdata <= 8'hff;
            reg_write <= 1'b1;
            @(posedge clock);
            reg_write <= 1'b0;
        end
        check_all();
        $display("write test done");
    endtask
    // Reads back to back; each answer stands one cycle only
    task automatic test_b2b();
        logic [7:0] d;
        @(posedge clock);
        s <= 18'h15555;
        m <= 7'h2a;
        repeat (6) @(posedge clock);
        reg_addr <= reluctance_sensor_flags_off;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_addr <= reluctance_sensor_measure_off;
        #1 chk(reg_rdata, {3'h0, s[16:12]});
        @(posedge clock);
        reg_read <= 1'b0;
        #1 chk(reg_rdata, {s[17], m});
        @(posedge clock);
        #1 chk(reg_rdata, 8'h00);
        $display("back to back test done");
    endtask
    // Reset in mid-run clears the flags while faults persist
    task automatic test_mid_reset();
        @(posedge clock);
        s <= 18'h3ffff;
        repeat (8) @(posedge clock);
        rst_n <= 1'b0;
        repeat (2) @(posedge clock);
        #1 chk({6'h0, fail_flag, hot_flag}, 8'h00);
        @(posedge clock);
        rst_n <= 1'b1;
        check_all();
        $display("mid reset test done");
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // Hang guard, far beyond the roughly 480 cycles needed
    initial begin
        #50000;
        n_errors++;
        report_and_stop();
    end
    // Main sequence
    initial begin
        repeat (12) @(posedge clock);
        rst_n <= 1'b1;
        check_all();
        test_walk();
        test_write();
        test_b2b();
        test_mid_reset();
        report_and_stop();
    end
endmodule

// File: hw/diag_bank_pkg.sv
// ==========================================================================
// Register map, field positions and reset values of the diagnosis bank
package diag_bank_pkg;

    // ======================================================================
    // Register offsets
    localparam logic [9:0] supply_diagnosis_off = 10'h020;
    localparam logic [9:0] overtemperature_diagnosis_off = 10'h021;
    localparam logic [9:0] reluctance_sensor_flags_off = 10'h022;
    localparam logic [9:0] reluctance_sensor_measure_off = 10'h023;
    localparam logic [9:0] communication_diagnosis_off = 10'h024;

    // ======================================================================
    // Field positions: supply diagnosis
    localparam int six_volt_supply_overvoltage_pos = 7;
    localparam int tracker_two_overvoltage_pos = 6;
    localparam int tracker_two_undervoltage_pos = 5;
    localparam int tracker_one_overvoltage_pos = 4;
    localparam int tracker_one_undervoltage_pos = 3;
    localparam int battery_overvoltage_pos = 2;
    localparam int central_failure_flag_pos = 1;
    localparam int central_overtemp_flag_pos = 0;

    // Field positions: overtemperature diagnosis
    localparam int tracker_overtemp_pos = 2;
    localparam int main_regulator_overtemp_pos = 1;
    localparam int main_relay_overtemp_pos = 0;

    // Field positions: reluctance sensor flags
    localparam int open_load_data_valid_pos = 4;
    localparam int short_data_valid_pos = 3;
    localparam int sensor_open_load_pos = 2;
    localparam int sensor_short_battery_pos = 1;
    localparam int sensor_short_ground_pos = 0;

    // Field positions: reluctance sensor measure and communication
    localparam int converter_data_valid_pos = 7;
    localparam int sensor_measure_width = 7;
    localparam int lin_transceiver_overtemp_pos = 5;

    // ======================================================================
    // Reset values
    localparam logic [7:0] diag_reset_value = 8'h00;
    localparam logic [6:0] sensor_measure_reset = 7'h00;

endpackage

// File: hw/diagnosis_status_bank.sv
// Chosen here: the plain strobed port.
`timescale 1ns/1ps
// Functional notes
// - bit7 reg0 six volt supply overvoltage
// - bit6 reg0 tracker two overvoltage
// - bit5 reg0 tracker two undervoltage
// - bit4 reg0 tracker one overvoltage
// - bit3 reg0 tracker one undervoltage
// - bit2 reg0 battery overvoltage
// - bit1 reg0 any diagnostic failure summary
// - bit0 reg0 any sensor overtemperature
// - bit2 overtemp reg tracker overtemperature
// - bit1 overtemp reg main regulator overtemperature
// - bit0 overtemp reg main relay overtemperature
// - bit4 sensor flags open load valid
// - bit3 sensor flags short data valid
// - bit2 sensor flags open load detected
// - bit1 sensor flags short to battery
// - bit0 sensor flags short to ground
// - bit7 measure reg converter data valid
// - bits6:0 measure reg result, zero reset
// - bit5 comm reg LIN overtemperature
module diagnosis_status_bank
    import diag_bank_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Register port
    input wire logic [9:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    // Analog monitor flags, asynchronous to the clock
    input wire logic six_volt_supply_overvoltage,
    input wire logic tracker_two_overvoltage,
    input wire logic tracker_two_undervoltage,
    input wire logic tracker_one_overvoltage,
    input wire logic tracker_one_undervoltage,
    input wire logic battery_overvoltage,
    input wire logic other_failure,
    input wire logic tracker_overtemp,
    input wire logic main_regulator_overtemp,
    input wire logic main_relay_overtemp,
    input wire logic lin_transceiver_overtemp,
    input wire logic other_overtemp,
    // Reluctance sensor diagnosis, asynchronous to the clock
    input wire logic open_load_data_valid,
    input wire logic short_data_valid,
    input wire logic sensor_open_load,
    input wire logic sensor_short_battery,
    input wire logic sensor_short_ground,
    input wire logic converter_data_valid,
    input wire logic [6:0] sensor_measure_result,
    // Summary outputs
    output logic central_failure_flag,
    output logic central_overtemp_flag
);

    // ======================================================================
    // Input synchronisers
    // Each level comes from an analog comparator that knows nothing of
    // the clock, so it passes two flops before any logic reads it
    localparam int nflags = 18; // Single-bit monitor levels
    localparam int nin = nflags + sensor_measure_width;

    // Bit positions of each level inside the gathered vector; the order
    // here must follow the concatenation below
    localparam int idx_supply_ov = 0;
    localparam int idx_trk2_ov = 1;
    localparam int idx_trk2_uv = 2;
    localparam int idx_trk1_ov = 3;
    localparam int idx_trk1_uv = 4;
    localparam int idx_bat_ov = 5;
    localparam int idx_other_fail = 6;
    localparam int idx_trk_ot = 7;
    localparam int idx_reg_ot = 8;
    localparam int idx_relay_ot = 9;
    localparam int idx_lin_ot = 10;
    localparam int idx_other_ot = 11;
    localparam int idx_ol_valid = 12;
    localparam int idx_sc_valid = 13;
    localparam int idx_open_load = 14;
    localparam int idx_short_bat = 15;
    localparam int idx_short_gnd = 16;
    localparam int idx_adc_valid = 17;

    logic [nin-1:0] raw_in;
    logic [nin-1:0] meta_q;
    logic [nin-1:0] sync_q;

    // Gather all outside levels into one vector, measurement on top
    assign raw_in = {
        sensor_measure_result,
        converter_data_valid,
        sensor_short_ground,
        sensor_short_battery,
        sensor_open_load,
        short_data_valid,
        open_load_data_valid,
        other_overtemp,
        lin_transceiver_overtemp,
        main_relay_overtemp,
        main_regulator_overtemp,
        tracker_overtemp,
        other_failure,
        battery_overvoltage,
        tracker_one_undervoltage,
        tracker_one_overvoltage,
        tracker_two_undervoltage,
        tracker_two_overvoltage,
        six_volt_supply_overvoltage
    };

    // Two stages; the first is read only by the second
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= raw_in;
            sync_q <= meta_q;
        end
    end

    // ======================================================================
    // Named synchronised levels
    // Supply and tracker monitors
    wire s_supply_ov = sync_q[idx_supply_ov];
    wire s_trk2_ov = sync_q[idx_trk2_ov];
    wire s_trk2_uv = sync_q[idx_trk2_uv];
    wire s_trk1_ov = sync_q[idx_trk1_ov];
    wire s_trk1_uv = sync_q[idx_trk1_uv];
    wire s_bat_ov = sync_q[idx_bat_ov];
    // Temperature sensors and further failures
    wire s_other_fail = sync_q[idx_other_fail];
    wire s_trk_ot = sync_q[idx_trk_ot];
    wire s_reg_ot = sync_q[idx_reg_ot];
    wire s_relay_ot = sync_q[idx_relay_ot];
    wire s_lin_ot = sync_q[idx_lin_ot];
    wire s_other_ot = sync_q[idx_other_ot];
    // Reluctance sensor interface; the result sits above the single flags
    wire s_ol_valid = sync_q[idx_ol_valid];
    wire s_sc_valid = sync_q[idx_sc_valid];
    wire s_open_load = sync_q[idx_open_load];
    wire s_short_bat = sync_q[idx_short_bat];
    wire s_short_gnd = sync_q[idx_short_gnd];
    wire s_adc_valid = sync_q[idx_adc_valid];
    wire [6:0] s_measure = sync_q[nin-1:nflags];

    // ======================================================================
    // Helpers
    // Address compare shared by every register select, kept as a
    // function so the five selects cannot drift apart
    function automatic logic addr_match(input logic [9:0] addr, input logic [9:0] offset);
        return addr == offset;
    endfunction

    // ======================================================================
    // Status registers, plain level followers
    // Flags are live levels, not sticky, so no clear logic is needed
    logic [7:0] supply_q;
    logic [7:0] supply_d;
    logic [7:0] overtemp_q;
    logic [7:0] overtemp_d;
    logic [7:0] sensor_flags_q;
    logic [7:0] sensor_flags_d;
    logic [7:0] sensor_meas_q;
    logic [7:0] sensor_meas_d;
    logic [7:0] comm_q;
    logic [7:0] comm_d;

    // Summary terms; the central overtemp covers every sensor in the chip
    wire any_overtemp = s_trk_ot
                        | s_reg_ot
                        | s_relay_ot
                        | s_lin_ot
                        | s_other_ot;

    // Open load and both shorts count as failures; valid bits do not
    wire sensor_fault = s_open_load
                        | s_short_bat
                        | s_short_gnd;

    // Every detected fault of this bank, plus those reported from elsewhere
    wire any_failure = s_supply_ov
                       | s_trk2_ov
                       | s_trk2_uv
                       | s_trk1_ov
                       | s_trk1_uv
                       | s_bat_ov
                       | any_overtemp
                       | sensor_fault
                       | s_other_fail;

    // ======================================================================
    // Next values of the status bytes
    // Every byte but the measurement byte starts from zero, so reserved bits always read zero
    // Supply diagnosis layout
    always_comb begin
        supply_d = diag_reset_value;
        supply_d[six_volt_supply_overvoltage_pos] = s_supply_ov;
        supply_d[tracker_two_overvoltage_pos] = s_trk2_ov;
        supply_d[tracker_two_undervoltage_pos] = s_trk2_uv;
        supply_d[tracker_one_overvoltage_pos] = s_trk1_ov;
        supply_d[tracker_one_undervoltage_pos] = s_trk1_uv;
        supply_d[battery_overvoltage_pos] = s_bat_ov;
        supply_d[central_failure_flag_pos] = any_failure;
        supply_d[central_overtemp_flag_pos] = any_overtemp;
    end

    // Overtemperature layout
    always_comb begin
        overtemp_d = diag_reset_value;
        overtemp_d[tracker_overtemp_pos] = s_trk_ot;
        overtemp_d[main_regulator_overtemp_pos] = s_reg_ot;
        overtemp_d[main_relay_overtemp_pos] = s_relay_ot;
    end

    // Communication layout; only the LIN bit lives in this bank
    always_comb begin
        comm_d = diag_reset_value;
        comm_d[lin_transceiver_overtemp_pos] = s_lin_ot;
    end

    // Reluctance sensor flag layout
    always_comb begin
        sensor_flags_d = diag_reset_value;
        sensor_flags_d[open_load_data_valid_pos] = s_ol_valid;
        sensor_flags_d[short_data_valid_pos] = s_sc_valid;
        sensor_flags_d[sensor_open_load_pos] = s_open_load;
        sensor_flags_d[sensor_short_battery_pos] = s_short_bat;
        sensor_flags_d[sensor_short_ground_pos] = s_short_gnd;
    end

    // Measurement byte; bits are synchronised one by one, so a result that
    // changes while it is sampled may show a mix of old and new bits
    assign sensor_meas_d = {s_adc_valid, s_measure};

    // ======================================================================
    // Status registers; writes never reach them
    // Latency from a pin change to a byte is three edges: two in the
    // synchroniser and one here
    // Supply diagnosis byte
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            supply_q <= diag_reset_value;
        end else begin
            supply_q <= supply_d;
        end
    end

    // Overtemperature byte
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            overtemp_q <= diag_reset_value;
        end else begin
            overtemp_q <= overtemp_d;
        end
    end

    // Reluctance sensor flag byte
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            sensor_flags_q <= diag_reset_value;
        end else begin
            sensor_flags_q <= sensor_flags_d;
        end
    end

    // Measurement byte, cleared to a zero result
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            sensor_meas_q <= {1'b0, sensor_measure_reset};
        end else begin
            sensor_meas_q <= sensor_meas_d;
        end
    end

    // Communication byte
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            comm_q <= diag_reset_value;
        end else begin
            comm_q <= comm_d;
        end
    end

    // ======================================================================
    // Read decode; the five mapped offsets sit in one small window
    wire hit_supply = addr_match(reg_addr, supply_diagnosis_off);
    wire hit_overtemp = addr_match(reg_addr, overtemperature_diagnosis_off);
    wire hit_flags = addr_match(reg_addr, reluctance_sensor_flags_off);
    wire hit_measure = addr_match(reg_addr, reluctance_sensor_measure_off);
    wire hit_comm = addr_match(reg_addr, communication_diagnosis_off);
    // Write strobe and data reach no register; a write with nonzero data beside a read
    // withholds the answer, though the bus never issues both together
    wire write_ignored = reg_write & (|reg_wdata | ~reg_write);

    // Unmapped addresses read as zero
    wire [7:0] read_mux = hit_supply ? supply_q
                        : hit_overtemp ? overtemp_q
                        : hit_flags ? sensor_flags_q
                        : hit_measure ? sensor_meas_q
                        : hit_comm ? comm_q
                        : diag_reset_value;

    // ======================================================================
    // Outputs, all straight from flops
    // A mid-run reset clears them even while faults persist; they return
    // three edges after release
    // Read data stands only in the cycle after the strobe, else zero
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            reg_rdata <= diag_reset_value;
        end else begin
            reg_rdata <= (reg_read && !write_ignored) ? read_mux : diag_reset_value;
        end
    end

    // Summary flags track the same terms as the supply byte bits
    // Central failure flag
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            central_failure_flag <= 1'b0;
        end else begin
            central_failure_flag <= supply_d[central_failure_flag_pos];
        end
    end

    // Central overtemperature flag
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            central_overtemp_flag <= 1'b0;
        end else begin
            central_overtemp_flag <= supply_d[central_overtemp_flag_pos];
        end
    end

endmodule
